/* File: hw/pcs_config_regs.sv */
// Contract
// - Detected parity fault flag sets on any address or data parity error.
// - System fault flag sets when reporting enabled and a system error signalled.
// - Master abort flag sets when own master cycle ends in master abort.
// - Received target abort flag sets when own cycle is target-aborted.
// - Signalled target abort flag sets when we target-abort a transaction.
// - Status bits 10:9 read fixed 01b, medium select timing.
// - Data parity flag sets only on PERR, we mastered, and response enabled.
// - Status bit 7 reads zero, no back-to-back target support.
// - Status bit 6 reads zero, no user-definable features.
// - Status bit 5 reads zero, not fast clock capable.
// - Status bit 4 reads one, capability list present.
// - Status bits 3:0 reserved, read zero.
// - Class and revision register at 08h is read-only.
// - Class bits 31:24 read 0Ch, serial bus controller.
// - Class bits 23:16 read 00h, the serial bus kind.
// - Class bits 15:8 read 10h, programming model code.
// - Class bits 7:0 return the silicon revision, fixed in hardware.
// - Register at 0Ch is fully read/write, 16 bits, resets 0000h.
// - Status lives at offset 06h and resets to 0210h.
// - System fault report enable is a read/write command bit gating SERR.
// - Parity response enable is a read/write command bit gating PERR.
// - At 0Ch, upper byte latency timer, lower byte line size.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.svh"

module pcs_config_regs #(
   parameter logic [7:0] SILICON_REVISION = 8'h00 // Arbitrary value
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cfg_sel,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_ack,
   input wire logic ev_parity_fault,
   input wire logic ev_system_fault,
   input wire logic ev_master_abort,
   input wire logic ev_target_abort_rcvd,
   input wire logic ev_target_abort_sent,
   input wire logic ev_perr_seen,
   input wire logic ev_master_phase,
   output logic system_fault_report_enable,
   output logic parity_response_enable,
   output logic [7:0] latency_timer,
   output logic [7:0] line_size_setting
);

   // Byte enables of one half word widened to a bit mask
   function automatic logic [15:0] lane_mask(input logic [1:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction

   // Byte-lane merge of a half word write
   function automatic logic [15:0] lane_merge(input logic [15:0] old_val,
                                              input logic [15:0] new_val,
                                              input logic [1:0] be);
      lane_merge = (old_val & ~lane_mask(be)) | (new_val & lane_mask(be));
   endfunction

   pcs_pkg::pcs_state_t state_reg;
   pcs_pkg::pcs_state_t state_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [15:0] latency_reg;
   logic [15:0] latency_next;
   logic serr_en_reg;
   logic serr_en_next;
   logic perr_en_reg;
   logic perr_en_next;

   pcs_flag_if flag_bus ();

   pcs_flag_bank u_flags (
      .clk(clk),
      .rstn(rstn),
      .fb(flag_bus)
   );

   // Access decode; a request is taken only while idle
   wire logic in_idle = (state_reg == pcs_pkg::PCS_ST_IDLE);
   wire logic take = in_idle && cfg_sel;
   wire logic take_wr = take && cfg_wr;
   wire logic take_rd = take && !cfg_wr;
   wire logic [7:0] dword_addr = {cfg_addr[7:2], 2'b00};
   wire logic hit_cmd = (dword_addr == `PCS_OFF_COMMAND);
   wire logic hit_class = (dword_addr == `PCS_OFF_CLASS);
   wire logic hit_latency = (dword_addr == `PCS_OFF_LATENCY);
   wire logic [15:0] status_lanes = lane_mask(cfg_be[3:2]);

   // Event flag sets, each qualified as its cause requires
   wire pcs_pkg::pcs_flags_t flag_set;
   assign flag_set[`PCS_FLAG_PARITY] = ev_parity_fault;
   assign flag_set[`PCS_FLAG_SYSTEM] = ev_system_fault && serr_en_reg;
   assign flag_set[`PCS_FLAG_RECEIVED_MASTER_ABORT] = ev_master_abort;
   assign flag_set[`PCS_FLAG_TABORT_RCVD] = ev_target_abort_rcvd;
   assign flag_set[`PCS_FLAG_TABORT_SENT] = ev_target_abort_sent;
   assign flag_set[`PCS_FLAG_MASTER_DATA_PARITY_FAULT] =
      ev_perr_seen && ev_master_phase && perr_en_reg;
   assign flag_bus.set = flag_set;

   // Write-one-to-clear from the status half of dword 04h
   wire logic [15:0] status_clear_bits =
      (take_wr && hit_cmd) ? (cfg_wdata[31:16] & status_lanes) : 16'h0000;
   assign flag_bus.clr = {status_clear_bits[15:11], status_clear_bits[8]};

   // Status view: live flags plus hardwired capability bits
   wire pcs_pkg::pcs_flags_t flags = flag_bus.flags;
   wire logic [15:0] status_view = {
      flags[5:1],                    // 15..11
      `PCS_DEVSEL_MEDIUM,
      flags[`PCS_FLAG_MASTER_DATA_PARITY_FAULT],      // 8
      1'b0,
      1'b0,
      1'b0,
      1'b1,
      4'h0
   };

   // Command half: only the two enables are kept, the rest read zero
   wire logic [15:0] command_view =
      (16'(serr_en_reg) << `PCS_CMD_SERR_BIT) | (16'(perr_en_reg) << `PCS_CMD_PERR_BIT);

   // Class code is a constant; nothing here can write it
   wire logic [31:0] class_view = {
      `PCS_BASE_CATEGORY,
      `PCS_SUB_CATEGORY,
      `PCS_PROG_MODEL,
      SILICON_REVISION
   };

   // Read multiplexer; header type and unmapped words read zero
   wire logic [31:0] read_mux =
      hit_cmd ? {status_view, command_view} :
      hit_class ? class_view :
      hit_latency ? {16'h0000, latency_reg} :
      32'h0000_0000;

   // Register writes honour byte enables
   wire logic wr_cmd = take_wr && hit_cmd;
   wire logic wr_latency = take_wr && hit_latency;
   wire logic [15:0] cmd_written = lane_merge(command_view, cfg_wdata[15:0], cfg_be[1:0]);
   assign serr_en_next = wr_cmd ? cmd_written[`PCS_CMD_SERR_BIT] : serr_en_reg;
   assign perr_en_next = wr_cmd ? cmd_written[`PCS_CMD_PERR_BIT] : perr_en_reg;
   assign latency_next = wr_latency ?
      lane_merge(latency_reg, cfg_wdata[15:0], cfg_be[1:0]) : latency_reg;

   // Read data captured at the take so it is stable during ack
   assign rdata_next = take_rd ? read_mux : rdata_reg;

   // Sequencer: every taken request answers one cycle later
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         pcs_pkg::PCS_ST_IDLE: begin
            if (cfg_sel) begin
               state_next = pcs_pkg::PCS_ST_ACK;
            end
         end
         pcs_pkg::PCS_ST_ACK: begin
            state_next = pcs_pkg::PCS_ST_IDLE;
         end
         default: begin
            state_next = pcs_pkg::PCS_ST_IDLE;
         end
      endcase
   end

   // State and data registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= pcs_pkg::PCS_ST_IDLE;
         rdata_reg <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
         rdata_reg <= rdata_next;
      end
   end

   // Host-programmable registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         latency_reg <= `PCS_LATENCY_RESET;
         serr_en_reg <= 1'b0;
         perr_en_reg <= 1'b0;
      end else begin
         latency_reg <= latency_next;
         serr_en_reg <= serr_en_next;
         perr_en_reg <= perr_en_next;
      end
   end

   // Outputs; the enables also steer flag qualification above
   assign cfg_ack = (state_reg == pcs_pkg::PCS_ST_ACK);
   assign cfg_rdata = rdata_reg;
   assign system_fault_report_enable = serr_en_reg;
   assign parity_response_enable = perr_en_reg;
   assign latency_timer = latency_reg[15:8];
   assign line_size_setting = latency_reg[7:0];

   // Checks on the visible behaviour
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   sequence s_class_read;
      take_rd && hit_class;
   endsequence

   sequence s_full_latency_write;
      take_wr && hit_latency && (cfg_be[1:0] == 2'b11);
   endsequence

   sequence s_flag_clear;
      take_wr && hit_cmd && cfg_be[3] && cfg_wdata[31];
   endsequence

   property p_event_sets(ev, flag);
      ev |=> flag;
   endproperty

   // A flag may fall only on a write of one into its own lane
   property p_flag_holds(flag, lane, bit_in);
      flag && !(wr_cmd && lane && bit_in) |=> flag;
   endproperty

   // Each event reaches its flag, and nothing else raises the parity, system or data parity flag
   chk_parity_sets: assert property (p_event_sets(ev_parity_fault, status_view[15]))
      else $error("parity fault flag did not set");

   chk_parity_cause: assert property ($rose(status_view[15]) |-> $past(ev_parity_fault))
      else $error("parity fault flag set without a cause");

   chk_system_sets: assert property (p_event_sets(ev_system_fault && serr_en_reg,
                                                  status_view[14]))
      else $error("system fault flag did not set");

   chk_system_gate: assert property ($rose(status_view[14]) |->
                                     $past(ev_system_fault) && $past(serr_en_reg))
      else $error("system fault flag set without enabled cause");

   chk_master_abort: assert property (p_event_sets(ev_master_abort, status_view[13]))
      else $error("master abort flag did not set");

   chk_target_rcvd: assert property (p_event_sets(ev_target_abort_rcvd,
                                                  status_view[12]))
      else $error("received target abort flag did not set");

   chk_target_sent: assert property (p_event_sets(ev_target_abort_sent,
                                                  status_view[11]))
      else $error("signalled target abort flag did not set");

   chk_master_data_parity_fault_sets: assert property (p_event_sets(ev_perr_seen && ev_master_phase &&
                                                   perr_en_reg, status_view[8]))
      else $error("data parity flag did not set");

   chk_master_data_parity_fault_cause: assert property ($rose(status_view[8]) |->
                                       $past(ev_perr_seen && ev_master_phase && perr_en_reg))
      else $error("data parity flag set without all three causes");

   // Flags survive until a one lands on them; a same-cycle event wins
   chk_flag_sticky: assert property (p_flag_holds(status_view[15],
                                                  cfg_be[3], cfg_wdata[31]))
      else $error("parity flag dropped without a clearing write");

   chk_system_holds: assert property (p_flag_holds(status_view[14],
                                                   cfg_be[3], cfg_wdata[30]))
      else $error("system fault flag dropped without a clearing write");

   chk_received_master_abort_holds: assert property (p_flag_holds(status_view[13],
                                                   cfg_be[3], cfg_wdata[29]))
      else $error("master abort flag dropped without a clearing write");

   chk_trcvd_holds: assert property (p_flag_holds(status_view[12],
                                                  cfg_be[3], cfg_wdata[28]))
      else $error("received target abort flag dropped without a clearing write");

   chk_tsent_holds: assert property (p_flag_holds(status_view[11],
                                                  cfg_be[3], cfg_wdata[27]))
      else $error("signalled target abort flag dropped without a clearing write");

   chk_master_data_parity_fault_holds: assert property (p_flag_holds(status_view[8],
                                                    cfg_be[2], cfg_wdata[24]))
      else $error("data parity flag dropped without a clearing write");

   chk_flag_clears: assert property (s_flag_clear and !ev_parity_fault |=>
                                     !status_view[15])
      else $error("parity flag not cleared by write of one");

   chk_master_data_parity_fault_clears: assert property (wr_cmd && cfg_be[2] && cfg_wdata[24] &&
                                        !flag_set[`PCS_FLAG_MASTER_DATA_PARITY_FAULT] |=> !status_view[8])
      else $error("data parity flag not cleared by write of one");

   chk_zero_write: assert property (wr_cmd && (cfg_wdata[31:16] == 16'h0000) &&
                                    (flag_set == '0) |=> flags == $past(flags))
      else $error("write of zeros changed a status flag");

   // Hardwired status bits, whatever the flags hold
   chk_fixed_bits: assert property ({status_view[10:9], status_view[7:0]} == 10'h110)
      else $error("hardwired status bits wrong");

   // Class word fields and its immunity to writes
   chk_class_read: assert property (s_class_read |=> cfg_ack &&
                                    cfg_rdata == {8'h0c, 8'h00, 8'h10, SILICON_REVISION})
      else $error("class code read returned wrong value");

   chk_class_sub: assert property (s_class_read |=> cfg_rdata[23:16] == 8'h00)
      else $error("class sub category wrong");

   chk_class_model: assert property (s_class_read |=> cfg_rdata[15:8] == 8'h10)
      else $error("programming model code wrong");

   chk_class_rev: assert property (s_class_read |=> cfg_rdata[7:0] == SILICON_REVISION)
      else $error("silicon revision wrong");

   chk_class_ro: assert property (take_wr && hit_class |=> $stable(latency_reg) &&
                                  $stable({serr_en_reg, perr_en_reg, cfg_rdata}))
      else $error("write to class code had an effect");

   // Line size register lanes, readback and the command enables
   chk_latency_write: assert property (s_full_latency_write |=>
                                       latency_reg == $past(cfg_wdata[15:0]))
      else $error("latency register did not take full write");

   chk_latency_read: assert property (take_rd && hit_latency |=>
                                      cfg_rdata == {16'h0000, $past(latency_reg)})
      else $error("latency register read returned wrong value");

   chk_upper_lane: assert property (wr_latency && !cfg_be[1] |=>
                                    latency_timer == $past(latency_timer))
      else $error("latency timer changed without its lane");

   chk_lower_lane: assert property (wr_latency && !cfg_be[0] |=>
                                    line_size_setting == $past(line_size_setting))
      else $error("line size changed without its lane");

   chk_serr_write: assert property (wr_cmd && cfg_be[1] |=>
                                    serr_en_reg == $past(cfg_wdata[`PCS_CMD_SERR_BIT]))
      else $error("system fault report enable did not take write");

   chk_perr_write: assert property (wr_cmd && cfg_be[0] |=>
                                    perr_en_reg == $past(cfg_wdata[`PCS_CMD_PERR_BIT]))
      else $error("parity response enable did not take write");

   // Handshake and unmapped space
   chk_unmapped_read: assert property (take_rd && !hit_cmd && !hit_class && !hit_latency |=>
                                       cfg_rdata == 32'h0000_0000)
      else $error("unmapped read returned data");

   chk_ack_pulse: assert property (take |=> cfg_ack ##1 !cfg_ack)
      else $error("answer not a single cycle after request");

endmodule

`default_nettype wire

/* File: hw/pcs_defs.svh */
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

// Configuration byte offsets
`define PCS_OFF_COMMAND 8'h04
`define PCS_OFF_STATUS 8'h06
`define PCS_OFF_CLASS 8'h08
`define PCS_OFF_LATENCY 8'h0c

// Command enables kept here
`define PCS_CMD_SERR_BIT 8
`define PCS_CMD_PERR_BIT 6

// Status layout
`define PCS_STATUS_RESET 16'h0210
`define PCS_DEVSEL_MEDIUM 2'b01
`define PCS_FLAG_COUNT 6
`define PCS_FLAG_PARITY 5
`define PCS_FLAG_SYSTEM 4
`define PCS_FLAG_RECEIVED_MASTER_ABORT 3
`define PCS_FLAG_TABORT_RCVD 2
`define PCS_FLAG_TABORT_SENT 1
`define PCS_FLAG_MASTER_DATA_PARITY_FAULT 0

// Class code fields
`define PCS_BASE_CATEGORY 8'h0c
`define PCS_SUB_CATEGORY 8'h00
`define PCS_PROG_MODEL 8'h10

// Latency and line size
`define PCS_LATENCY_RESET 16'h0000

`endif

/* File: hw/pcs_flag_bank.sv */
`timescale 1ns/1ps
`default_nettype none

module pcs_flag_bank (
   input wire logic clk,
   input wire logic rstn,
   pcs_flag_if.sink fb
);

   pcs_pkg::pcs_flags_t flags_reg;
   pcs_pkg::pcs_flags_t flags_next;

   // Set wins over a clear landing in the same cycle
   assign flags_next = (flags_reg & ~fb.clr) | fb.set;
   assign fb.flags = flags_reg;

   // Sticky event flags
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags_reg <= '0;
      end else begin
         flags_reg <= flags_next;
      end
   end

endmodule

`default_nettype wire

/* File: hw/pcs_flag_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface pcs_flag_if;
   pcs_pkg::pcs_flags_t set;
   pcs_pkg::pcs_flags_t clr;
   pcs_pkg::pcs_flags_t flags;
   modport source (output set, output clr, input flags);
   modport sink (input set, input clr, output flags);
endinterface

`default_nettype wire

/* File: hw/pcs_pkg.sv */
package pcs_pkg;

   // Access sequencer states, one-hot
   typedef enum logic [1:0] {
      PCS_ST_IDLE = 2'b01,
      PCS_ST_ACK = 2'b10
   } pcs_state_t;

   // Flag vector order: 15, 14, 13, 12, 11, 8
   typedef logic [5:0] pcs_flags_t;

endpackage

/* File: tb/pcs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Host side of the config bus: one request at a time, held until acked
module pcs_host_model (
   input wire logic clk,
   input wire logic cfg_ack,
   output logic cfg_sel,
   output logic cfg_wr,
   output logic [7:0] cfg_addr,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata
);
   // Idle bus shows a non-zero pattern so stale values never look valid
   initial begin
      cfg_sel = 1'b0;
      cfg_wr = 1'b1;
      cfg_addr = 8'hff;
      cfg_be = 4'hf;
      cfg_wdata = 32'ha5a5a5a5;
   end

   // Hold request until the edge that samples ack, then release
   task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                         input logic [31:0] wdata);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      cfg_sel = 1'b1;
      cfg_wr = wr;
      cfg_addr = addr;
      cfg_be = be;
      cfg_wdata = wdata;
      while (cfg_ack !== 1'b1 && n < 16) begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
      cfg_sel = 1'b0; // Dropped at the edge after ack, else taken again
      cfg_wr = ~wr;
      cfg_addr = ~addr;
      cfg_be = ~be;
      cfg_wdata = ~wdata;
   endtask
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam logic [7:0] REV = 8'h5a; // Arbitrary revision
   logic clk = 1'b0;
   logic rstn;
   logic cfg_sel, cfg_wr, cfg_ack;
   logic [7:0] cfg_addr, latency_timer, line_size_setting;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, rng, d;
   logic system_fault_report_enable, parity_response_enable;
   logic [6:0] ev;
   logic [5:0] exp_flags = 6'h00;
   logic [15:0] cmd = 16'h0000;
   logic [15:0] lat = 16'h0000;
   logic [32:0] notes[$];
   logic [32:0] note;
   int mismatches = 0;
   int cmp_count = 0;

   // 50 MHz clock
   always #10 clk = ~clk;

   pcs_host_model u_host (.clk(clk), .cfg_ack(cfg_ack), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));

   pcs_config_regs #(.SILICON_REVISION(REV)) u_dut (.clk(clk), .rstn(rstn),
      .cfg_sel(cfg_sel), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
      .ev_parity_fault(ev[6]), .ev_system_fault(ev[5]), .ev_master_abort(ev[4]),
      .ev_target_abort_rcvd(ev[3]), .ev_target_abort_sent(ev[2]),
      .ev_perr_seen(ev[1]), .ev_master_phase(ev[0]),
      .system_fault_report_enable(system_fault_report_enable),
      .parity_response_enable(parity_response_enable),
      .latency_timer(latency_timer), .line_size_setting(line_size_setting));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function logic [31:0] nxt();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   // Expected dword 04h from the flag model
   function logic [31:0] stat();
      return {exp_flags[5:1], 2'b01, exp_flags[0], 8'h10, cmd};
   endfunction

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      notes.push_back({1'b1, e});
      u_host.access(1'b0, a, 4'hf, 32'h0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
      notes.push_back({1'b0, 32'h0});
      u_host.access(1'b1, a, be, v);
   endtask

   // One-cycle event burst; flags only set when their qualifiers hold
   task automatic fire(input logic [6:0] v);
      @(posedge clk);
      #1;
      ev = v;
      exp_flags |= {v[6], v[5] & cmd[8], v[4], v[3], v[2], v[1] & v[0] & cmd[6]};
      @(posedge clk);
      #1;
      ev = 7'h00;
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Result watcher: every ack retires the oldest note
   always @(posedge clk) begin
      #1;
      if (cfg_ack === 1'b1) begin
         if (notes.size() == 0) begin
            mismatches++;
            $display("[ERR] cfg_ack expected 0 seen 1");
         end else begin
            note = notes.pop_front();
            if (note[32]) begin
               check("cfg_rdata", cfg_rdata, note[31:0]);
            end
         end
      end
   end

   // Watchdog well beyond the expected run length
   initial begin
      #400000;
      mismatches++;
      conclude();
   end

   // Main sequence
   initial begin
      rstn = 1'b0;
      ev = 7'h00;
      rng = 32'd85054;
      repeat (10) @(posedge clk);
      #1;
      rstn = 1'b1;
      check("lat_out", {16'h0, latency_timer, line_size_setting}, 32'h0);
      rd(8'h04, stat());
      rd(8'h08, {8'h0c, 8'h00, 8'h10, REV});
      wr(8'h08, 4'hf, 32'hffffffff);
      rd(8'h08, {8'h0c, 8'h00, 8'h10, REV});
      rd(8'h0c, 32'h0);
      rd(8'h10, 32'h0);
      // Random lane mixes into 0Ch; upper half must stay zero
      for (int i = 0; i < 8; i++) begin
         d = nxt();
         if (d[0]) lat[7:0] = d[7:0];
         if (d[1]) lat[15:8] = d[15:8];
         wr(8'h0c, d[3:0], d);
         check("lat_out", {16'h0, latency_timer, line_size_setting}, {16'h0, lat});
         rd(8'h0c, {16'h0, lat});
      end
      // Each event source alone, then the parity pair, with enables off and on
      for (int k = 0; k < 2; k++) begin
         cmd = (k == 1) ? 16'h0140 : 16'h0000;
         wr(8'h04, 4'h3, {16'h0, cmd});
         check("enables", {30'h0, system_fault_report_enable, parity_response_enable},
               {30'h0, cmd[8], cmd[6]});
         for (int i = 0; i < 8; i++) begin
            fire((i == 7) ? 7'h03 : 7'(1 << i));
            rd(8'h04, stat());
            wr(8'h04, 4'hc, 32'h0);
            rd(8'h04, stat());
            wr(8'h04, 4'hc, 32'hffff0000);
            exp_flags = 6'h00;
            rd(8'h04, stat());
         end
      end
      // Random event mixes, then a clear on random lanes and bits
      for (int i = 0; i < 6; i++) begin
         d = nxt();
         fire(d[6:0]);
         rd(8'h04, stat());
         d = nxt();
         wr(8'h04, {d[3:2], 2'b00}, d);
         exp_flags &= ~({d[31:27], d[24]} & {{5{d[3]}}, d[2]});
         rd(8'h04, stat());
      end
      // Mid-run reset brings every register back to its reset value
      repeat (2) @(posedge clk);
      #1;
      rstn = 1'b0;
      cmd = 16'h0000;
      lat = 16'h0000;
      exp_flags = 6'h00;
      repeat (3) @(posedge clk);
      #1;
      rstn = 1'b1;
      check("lat_rst", {16'h0, latency_timer, line_size_setting}, 32'h0);
      check("enables_rst", {30'h0, system_fault_report_enable, parity_response_enable},
            32'h0);
      rd(8'h04, stat());
      rd(8'h0c, 32'h0);
      repeat (4) @(posedge clk);
      check("pending", 32'(notes.size()), 32'h0);
      conclude();
   end
endmodule

`default_nettype wire
